// ---- hdl/setr_exposure.sv ----
module setr_exposure #(
  parameter logic [7:0] BRIGHT_TARGET = 8'h80  // frame brightness aimed at
) (
  input  wire logic       clock_i,       // core clock
  input  wire logic       rst_b_i,       // async reset, active low
  input  wire logic       ae_on_i,       // automatic exposure enable
  input  wire logic       frame_done_i,  // one-cycle end of frame pulse
  input  wire logic [7:0] bright_i,      // frame brightness, valid with frame_done_i
  output logic [9:0]      expo_o         // current exposure code
);
  import setr_pkg::*;

  logic [9:0] expo, next_expo;  // exposure code register

  // one step per frame keeps the loop slow and stable
  always_comb begin
    next_expo = expo;
    if (!ae_on_i) begin
      next_expo = EXPO_FIXED_CODE;
    end else if (expo < EXPO_MIN_CODE) begin
      next_expo = EXPO_MIN_CODE;
    end else if (expo > EXPO_MAX_CODE) begin
      next_expo = EXPO_MAX_CODE;
    end else if (frame_done_i) begin
      if (bright_i < BRIGHT_TARGET && expo < EXPO_MAX_CODE) begin
        next_expo = expo + 10'h1;
      end else if (bright_i > BRIGHT_TARGET && expo > EXPO_MIN_CODE) begin
        next_expo = expo - 10'h1;
      end
    end
  end

  // register the exposure; reset starts at the fixed value
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      expo <= EXPO_FIXED_CODE;
    end else begin
      expo <= next_expo;
    end
  end

  assign expo_o = expo;

endmodule : setr_exposure

// ---- hdl/setr_pkg.sv ----
package setr_pkg;

  // clock and time base
  localparam int unsigned CLOCK_HZ      = 100_000_000;         // core clock rate
  localparam int unsigned MS_PER_S      = 1000;                // unit conversion
  localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / MS_PER_S; // cycles in one millisecond

  // register offsets on the management port
  localparam logic [7:0] ADDR_SLEEP_ENTRY_DELAY      = 8'h0b; // both sleep entry delays
  localparam logic [7:0] ADDR_DEEP_SLEEP_POLL_PERIOD = 8'h0c; // deep sleep polling period
  localparam logic [7:0] ADDR_AUTO_EXPOSURE_CONTROL  = 8'h20; // automatic exposure enable
  localparam logic [7:0] ADDR_EXPOSURE_TIME_LOW      = 8'h32; // exposure code [7:0]
  localparam logic [7:0] ADDR_EXPOSURE_TIME_HIGH     = 8'h33; // exposure code [9:8]
  localparam logic [7:0] ADDR_TOUCH_SCALING          = 8'h4d; // touch information scaling
  localparam logic [7:0] ADDR_TOUCH_STATE            = 8'h59; // touch flag

  // field positions
  localparam int unsigned LIGHT_DELAY_LSB  = 4; // light sleep delay in [7:4]
  localparam int unsigned DEEP_DELAY_LSB   = 0; // deep sleep delay in [3:0]
  localparam int unsigned POLL_PERIOD_LSB  = 4; // poll period in [7:4]
  localparam int unsigned AE_ON_BIT        = 0; // auto exposure enable bit
  localparam int unsigned TOUCH_SCALE_LSB  = 0; // scaling in [3:0]
  localparam int unsigned TOUCH_FLAG_BIT   = 7; // touch flag bit
  localparam int unsigned EXPO_LOW_W       = 8; // bits of exposure in the low register

  // reset values
  localparam logic [7:0] RST_SLEEP_ENTRY_DELAY      = 8'h37; // 1000 ms and 6000 ms
  localparam logic [7:0] RST_DEEP_SLEEP_POLL_PERIOD = 8'h71; // 96 ms, low nibble 0001
  localparam logic [7:0] RST_AUTO_EXPOSURE_CONTROL  = 8'h0f; // enabled, bits 3:1 set
  localparam logic [7:0] RST_TOUCH_SCALING          = 8'h1a; // full scale code 10
  localparam logic [7:0] RDATA_UNMAPPED             = 8'h00; // answer to unknown offsets

  // sleep timing in milliseconds
  localparam int unsigned MS_W          = 14;             // holds up to 12000 ms
  localparam logic [13:0] LIGHT_STEP_MS = 14'd250;        // light delay step
  localparam logic [13:0] DEEP_STEP_MS  = 14'd750;        // deep delay step
  localparam logic [7:0]  POLL_STEP_MS  = 8'd12;          // deep poll step

  // exposure code is linear in time
  localparam int unsigned EXPO_MIN_US    = 10;            // shortest exposure
  localparam int unsigned EXPO_MAX_US    = 160;           // longest exposure
  localparam int unsigned EXPO_FIXED_US  = 60;            // exposure with auto off
  localparam logic [9:0]  EXPO_MIN_CODE  = 10'd32;        // code at 10 us
  localparam logic [9:0]  EXPO_MAX_CODE  = 10'd512;       // code at 160 us
  localparam logic [9:0]  EXPO_FIXED_CODE =
    10'(EXPO_FIXED_US * 32 / EXPO_MIN_US);                // code at 60 us

  // touch scaling codes
  localparam logic [3:0] TOUCH_SCALE_FULL    = 4'ha;      // no scaling
  localparam logic [3:0] TOUCH_SCALE_HALF    = 4'h9;      // divide by two
  localparam logic [3:0] TOUCH_SCALE_QUARTER = 4'h8;      // divide by four

  // power state of the sensor
  typedef enum logic [2:0] {
    SETR_NORMAL = 3'b001,
    SETR_LIGHT  = 3'b010,
    SETR_DEEP   = 3'b100
  } setr_sleep_state_type;

endpackage : setr_pkg

// ---- hdl/setr_regs.sv ----
// Functional notes
// - light/deep sleep delays: (n+1)*250, (n+1)*750 ms
// - deep sleep poll period is (n+1)*12 ms
// - auto exposure adjusts 10-160 us, else 60
// - 10-bit exposure readout split over two registers
// - exposure code linear: 32=10 us, 512=160 us
// - touch scaling: 10 full, 9 half, 8 quarter
// - touch flag in bit 7, read only
module setr_regs #(
  parameter int unsigned MS_CYCLES     = setr_pkg::CYCLES_PER_MS, // cycles per millisecond
  parameter logic [7:0]  BRIGHT_TARGET = 8'h80                    // exposure loop target
) (
  input  wire logic                      clock_i,        // core clock, 100 MHz
  input  wire logic                      rst_b_i,        // async reset, active low
  input  wire logic [7:0]                reg_addr_i,     // register offset
  input  wire logic [7:0]                reg_wdata_i,    // write data
  input  wire logic                      reg_wr_i,       // write strobe, one cycle
  input  wire logic                      reg_rd_i,       // read strobe, one cycle
  output logic [7:0]                     reg_rdata_o,    // read data, held until next read
  output logic                           reg_rvalid_o,   // read data valid pulse
  input  wire logic                      touch_pin_i,    // raw touch detect, asynchronous
  input  wire logic [7:0]                touch_level_i,  // touch information from front end
  input  wire logic                      frame_done_i,   // end of frame pulse
  input  wire logic [7:0]                bright_i,       // frame brightness
  output setr_pkg::setr_sleep_state_type sleep_state_o,  // power state
  output logic                           poll_o,         // deep sleep poll pulse
  output logic [9:0]                     exposure_o,     // current exposure code
  output logic                           auto_exposure_on_o, // automatic exposure enabled
  output logic [7:0]                     touch_info_o,   // scaled touch information
  output logic                           touch_flag_o    // synchronised touch state
);
  import setr_pkg::*;

  // software writable registers
  logic [7:0] sleep_entry_delay;          // light and deep delay codes
  logic [7:0] next_sleep_entry_delay;     // next value
  logic [7:0] deep_sleep_poll_period;     // deep poll period code
  logic [7:0] next_deep_sleep_poll_period; // next value
  logic [7:0] auto_exposure_control;      // auto exposure enable
  logic [7:0] next_auto_exposure_control; // next value
  logic [7:0] touch_scaling;              // touch scaling code
  logic [7:0] next_touch_scaling;         // next value

  // read port
  logic [7:0] next_rdata;                 // read data next value
  logic       next_rvalid;                // read valid next value

  // touch path
  logic       touch_meta;                 // first synchroniser stage
  logic       touch_sync;                 // second synchroniser stage
  logic       touch_flag;                 // touch state seen by software
  logic       next_touch_flag;            // next value
  logic [7:0] touch_info;                 // scaled touch information
  logic [7:0] next_touch_info;            // next value

  // helper outputs and decoded register fields
  setr_sleep_state_type sleep_state;      // power state from sleep control
  logic                 poll;             // poll pulse from sleep control
  logic [9:0]           expo;             // exposure code
  logic [3:0]           light_n;          // light delay field
  logic [3:0]           deep_n;           // deep delay field
  logic [3:0]           poll_n;           // poll period field
  logic [3:0]           scale_n;          // touch scaling field
  logic                 ae_on;            // auto exposure bit

  // field extraction from the stored registers
  always_comb begin
    light_n = sleep_entry_delay[LIGHT_DELAY_LSB +: 4];
    deep_n  = sleep_entry_delay[DEEP_DELAY_LSB +: 4];
    poll_n  = deep_sleep_poll_period[POLL_PERIOD_LSB +: 4];
    scale_n = touch_scaling[TOUCH_SCALE_LSB +: 4];
    ae_on   = auto_exposure_control[AE_ON_BIT];
  end

  // register writes; read-only and unknown offsets ignore writes
  always_comb begin
    next_sleep_entry_delay      = sleep_entry_delay;
    next_deep_sleep_poll_period = deep_sleep_poll_period;
    next_auto_exposure_control  = auto_exposure_control;
    next_touch_scaling          = touch_scaling;
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_SLEEP_ENTRY_DELAY) begin
        next_sleep_entry_delay = reg_wdata_i;
      end else if (reg_addr_i == ADDR_DEEP_SLEEP_POLL_PERIOD) begin
        next_deep_sleep_poll_period = reg_wdata_i;
      end else if (reg_addr_i == ADDR_AUTO_EXPOSURE_CONTROL) begin
        next_auto_exposure_control = reg_wdata_i;
      end else if (reg_addr_i == ADDR_TOUCH_SCALING) begin
        next_touch_scaling = reg_wdata_i;
      end
    end
  end

  // store the writable registers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sleep_entry_delay      <= RST_SLEEP_ENTRY_DELAY;
      deep_sleep_poll_period <= RST_DEEP_SLEEP_POLL_PERIOD;
      auto_exposure_control  <= RST_AUTO_EXPOSURE_CONTROL;
      touch_scaling          <= RST_TOUCH_SCALING;
    end else begin
      sleep_entry_delay      <= next_sleep_entry_delay;
      deep_sleep_poll_period <= next_deep_sleep_poll_period;
      auto_exposure_control  <= next_auto_exposure_control;
      touch_scaling          <= next_touch_scaling;
    end
  end

  // read decode; the answer lands one cycle after the strobe
  always_comb begin
    next_rvalid = reg_rd_i;
    next_rdata  = reg_rdata_o;  // data holds between reads
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_SLEEP_ENTRY_DELAY) begin
        next_rdata = sleep_entry_delay;
      end else if (reg_addr_i == ADDR_DEEP_SLEEP_POLL_PERIOD) begin
        next_rdata = deep_sleep_poll_period;
      end else if (reg_addr_i == ADDR_AUTO_EXPOSURE_CONTROL) begin
        next_rdata = auto_exposure_control;
      end else if (reg_addr_i == ADDR_EXPOSURE_TIME_LOW) begin
        next_rdata = expo[EXPO_LOW_W-1:0];
      end else if (reg_addr_i == ADDR_EXPOSURE_TIME_HIGH) begin
        // upper two bits in the lowest positions, rest reserved as zero
        next_rdata = {6'h00, expo[9:EXPO_LOW_W]};
      end else if (reg_addr_i == ADDR_TOUCH_SCALING) begin
        next_rdata = touch_scaling;
      end else if (reg_addr_i == ADDR_TOUCH_STATE) begin
        next_rdata = 8'h00;
        next_rdata[TOUCH_FLAG_BIT] = touch_flag;
      end else begin
        next_rdata = RDATA_UNMAPPED;
      end
    end
  end

  // register the read answer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o  <= next_rdata;
      reg_rvalid_o <= next_rvalid;
    end
  end

  // touch detect arrives from the analog front end, so resynchronise it
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      touch_meta <= 1'b0;
      touch_sync <= 1'b0;
    end else begin
      touch_meta <= touch_pin_i;
      touch_sync <= touch_meta;
    end
  end

  // touch flag and scaled information
  always_comb begin
    next_touch_flag = touch_sync;
    // unlisted codes pass full scale rather than guess a divisor
    if (scale_n == TOUCH_SCALE_HALF) begin
      next_touch_info = {1'b0, touch_level_i[7:1]};
    end else if (scale_n == TOUCH_SCALE_QUARTER) begin
      next_touch_info = {2'b00, touch_level_i[7:2]};
    end else begin
      next_touch_info = touch_level_i;
    end
  end

  // register touch outputs
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      touch_flag <= 1'b0;
      touch_info <= 8'h00;
    end else begin
      touch_flag <= next_touch_flag;
      touch_info <= next_touch_info;
    end
  end

  // sleep timing; uses the flag so sleep and software see one touch view
  setr_sleep_ctrl #(
    .MS_CYCLES (MS_CYCLES)
  ) u_sleep (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .touch_i   (touch_flag),
    .light_n_i (light_n),
    .deep_n_i  (deep_n),
    .poll_n_i  (poll_n),
    .state_o   (sleep_state),
    .poll_o    (poll)
  );

  // exposure control loop
  setr_exposure #(
    .BRIGHT_TARGET (BRIGHT_TARGET)
  ) u_expo (
    .clock_i      (clock_i),
    .rst_b_i      (rst_b_i),
    .ae_on_i      (ae_on),
    .frame_done_i (frame_done_i),
    .bright_i     (bright_i),
    .expo_o       (expo)
  );

  // outputs come from flip-flops here or in the helpers
  assign sleep_state_o      = sleep_state;
  assign poll_o             = poll;
  assign exposure_o         = expo;
  assign auto_exposure_on_o = auto_exposure_control[AE_ON_BIT];
  assign touch_info_o       = touch_info;
  assign touch_flag_o       = touch_flag;

endmodule : setr_regs

// ---- hdl/setr_sleep_ctrl.sv ----
module setr_sleep_ctrl #(
  parameter int unsigned MS_CYCLES = setr_pkg::CYCLES_PER_MS  // cycles per millisecond
) (
  input  wire logic                           clock_i,      // core clock
  input  wire logic                           rst_b_i,      // async reset, active low
  input  wire logic                           touch_i,      // synchronised touch level
  input  wire logic [3:0]                     light_n_i,    // light sleep delay code
  input  wire logic [3:0]                     deep_n_i,     // deep sleep delay code
  input  wire logic [3:0]                     poll_n_i,     // deep poll period code
  output setr_pkg::setr_sleep_state_type      state_o,      // current power state
  output logic                                poll_o        // one-cycle deep poll pulse
);
  import setr_pkg::*;

  setr_sleep_state_type state, next_state;   // power state
  logic [31:0]          tick, next_tick;     // millisecond prescaler
  logic [MS_W-1:0]      idle_ms, next_idle;  // no-touch time in ms
  logic [7:0]           poll_ms, next_poll;  // ms since last poll
  logic                 next_poll_o;         // poll pulse next value
  logic                 ms_pulse;            // one millisecond elapsed
  logic [MS_W-1:0]      light_limit;         // (n+1)*250
  logic [MS_W-1:0]      deep_limit;          // (n+1)*750
  logic [7:0]           poll_limit;          // (n+1)*12

  // delays are computed, not tabled, so any code 0..15 works
  always_comb begin
    light_limit = MS_W'((MS_W'(light_n_i) + 14'd1) * LIGHT_STEP_MS);
    deep_limit  = MS_W'((MS_W'(deep_n_i) + 14'd1) * DEEP_STEP_MS);
    poll_limit  = 8'((8'(poll_n_i) + 8'd1) * POLL_STEP_MS);
    ms_pulse    = (tick == 32'(MS_CYCLES - 1));
    next_tick   = ms_pulse ? 32'h0 : tick + 32'h1;
    next_idle   = idle_ms;
    next_poll   = poll_ms;
    next_poll_o = 1'b0;
    next_state  = state;
    if (touch_i) begin
      // any touch restarts the whole no-touch timing
      next_state = SETR_NORMAL;
      next_tick  = 32'h0;
      next_idle  = '0;
      next_poll  = 8'h0;
    end else begin
      // saturate so a long idle does not wrap back to normal
      if (ms_pulse && idle_ms != {MS_W{1'b1}}) begin
        next_idle = idle_ms + 14'd1;
      end
      case (state)
        SETR_NORMAL: begin
          if (idle_ms >= deep_limit) begin
            next_state = SETR_DEEP;
          end else if (idle_ms >= light_limit) begin
            next_state = SETR_LIGHT;
          end
        end
        SETR_LIGHT: begin
          if (idle_ms >= deep_limit) begin
            next_state = SETR_DEEP;
          end
        end
        SETR_DEEP: begin
          // poll once per period while deeply asleep
          if (ms_pulse) begin
            if (poll_ms >= poll_limit - 8'h1) begin
              next_poll   = 8'h0;
              next_poll_o = 1'b1;
            end else begin
              next_poll = poll_ms + 8'h1;
            end
          end
        end
        default: begin
          next_state = SETR_NORMAL;
        end
      endcase
    end
  end

  // register the timing state
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state   <= SETR_NORMAL;
      tick    <= 32'h0;
      idle_ms <= '0;
      poll_ms <= 8'h0;
      poll_o  <= 1'b0;
    end else begin
      state   <= next_state;
      tick    <= next_tick;
      idle_ms <= next_idle;
      poll_ms <= next_poll;
      poll_o  <= next_poll_o;
    end
  end

  assign state_o = state;

endmodule : setr_sleep_ctrl

// ---- verification/setr_host.sv ----
module setr_host (
  input  wire logic       clock_i,     // core clock
  output logic [7:0]      reg_addr_o,  // register offset
  output logic [7:0]      reg_wdata_o, // write data
  output logic            reg_wr_o,    // write strobe
  output logic            reg_rd_o,    // read strobe
  input  wire logic [7:0] reg_rdata_i, // read data
  input  wire logic       reg_rvalid_i // read valid
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle port at time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // one-cycle strobe; the next call waits an edge, so strobes never merge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clock_i);
    reg_wr_o    <= 1'b0;
  endtask : write

  // read strobe, then a short bounded wait for the valid pulse
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clock_i);
    reg_rd_o   <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 3 && !ok; i++) begin
      #1;
      ok = (reg_rvalid_i === 1'b1);
      d  = reg_rdata_i;
      if (!ok) @(posedge clock_i);
    end
  endtask : read
endmodule : setr_host

// ---- verification/setr_regs_sva.sv ----
module setr_regs_sva
  import setr_pkg::*;
#(
  parameter int unsigned MS_CYCLES     = 4,    // cycles per millisecond
  parameter logic [7:0]  BRIGHT_TARGET = 8'h80 // exposure loop target
) (
  input wire logic                           clock_i,            // core clock
  input wire logic                           rst_b_i,            // reset, active low
  input wire logic [7:0]                     reg_addr_i,         // register offset
  input wire logic [7:0]                     reg_wdata_i,        // write data
  input wire logic                           reg_wr_i,           // write strobe
  input wire logic                           reg_rd_i,           // read strobe
  input wire logic [7:0]                     reg_rdata_o,        // read data
  input wire logic                           reg_rvalid_o,       // read valid
  input wire logic                           touch_pin_i,        // raw touch
  input wire logic [7:0]                     touch_level_i,      // touch information
  input wire logic                           frame_done_i,       // frame end pulse
  input wire logic [7:0]                     bright_i,           // frame brightness
  input wire setr_pkg::setr_sleep_state_type sleep_state_o,      // power state
  input wire logic                           poll_o,             // deep poll pulse
  input wire logic [9:0]                     exposure_o,         // exposure code
  input wire logic                           auto_exposure_on_o, // auto exposure on
  input wire logic [7:0]                     touch_info_o,       // scaled touch
  input wire logic                           touch_flag_o        // touch state
);
  timeunit 1ns;
  timeprecision 1ns;

  // one domain, so clock and reset are stated once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe not answered next cycle");
  // a valid with no read behind it would hand stale data to the host
  a_no_stray_valid: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read valid without a read");
  a_flag_readback: assert property (reg_rd_i && reg_addr_i == ADDR_TOUCH_STATE |=>
    reg_rdata_o == {$past(touch_flag_o), 7'h00}) else $error("touch flag readback wrong");
  a_expo_low_read: assert property (reg_rd_i && reg_addr_i == ADDR_EXPOSURE_TIME_LOW |=>
    reg_rdata_o == $past(exposure_o[7:0])) else $error("exposure low byte wrong");
  a_expo_high_read: assert property (reg_rd_i && reg_addr_i == ADDR_EXPOSURE_TIME_HIGH
    |=> reg_rdata_o == {6'h00, $past(exposure_o[9:8])}) else $error("exposure high byte wrong");
  a_expo_in_range: assert property (exposure_o inside {[EXPO_MIN_CODE:EXPO_MAX_CODE]})
    else $error("exposure code out of range");
  // with auto exposure off the code is pinned, frames or not
  a_fixed_expo: assert property (!$past(auto_exposure_on_o) |->
    exposure_o == EXPO_FIXED_CODE) else $error("exposure not fixed while auto is off");
  a_touch_wakes: assert property (touch_flag_o |=> sleep_state_o == SETR_NORMAL)
    else $error("touch did not wake the sensor");
  a_poll_in_deep: assert property (poll_o |-> $past(sleep_state_o) == SETR_DEEP)
    else $error("poll pulse outside deep sleep");

  c_deep: cover property (sleep_state_o == SETR_DEEP);
  c_poll: cover property (poll_o);
  c_flag_read: cover property (reg_rd_i && reg_addr_i == ADDR_TOUCH_STATE && touch_flag_o);
endmodule : setr_regs_sva

bind setr_regs setr_regs_sva #(.MS_CYCLES(MS_CYCLES), .BRIGHT_TARGET(BRIGHT_TARGET)) u_sva (
  .clock_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .reg_rvalid_o, .touch_pin_i, .touch_level_i, .frame_done_i, .bright_i, .sleep_state_o,
  .poll_o, .exposure_o, .auto_exposure_on_o, .touch_info_o, .touch_flag_o);

// ---- verification/sleep_exposure_touch_regs_bench.sv ----
module sleep_exposure_touch_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import setr_pkg::*;

  localparam int unsigned MSC = 4; // short millisecond keeps the sleep run brief
  logic                 clock_i = 1'b0;              // core clock
  logic                 rst_b_i = 1'b0;              // reset, active low
  logic                 touch_pin_i = 1'b0;          // raw touch
  logic                 frame_done_i = 1'b0;         // frame end pulse
  logic [7:0]           touch_level_i = 8'h00;       // touch information
  logic [7:0]           bright_i = 8'h00;            // frame brightness
  logic [7:0]           reg_addr_i, reg_wdata_i;     // host request
  logic                 reg_wr_i, reg_rd_i;          // host strobes
  logic [7:0]           reg_rdata_o, touch_info_o;   // design answers
  logic                 reg_rvalid_o, poll_o;        // design pulses
  logic                 auto_exposure_on_o, touch_flag_o; // design levels
  logic [9:0]           exposure_o;                  // exposure code
  setr_sleep_state_type sleep_state_o;               // power state
  int                   mismatches = 0;              // failed compares
  int                   checks = 0;                  // compares made
  int                   n;                           // cycle count
  logic [31:0]          seed = 32'hc126;             // stimulus lfsr
  logic [7:0] addr_t [8] = '{8'h0b, 8'h0c, 8'h20, 8'h4d, 8'h32, 8'h33, 8'h59, 8'h7f};
  logic [7:0] rst_t [8]  = '{8'h37, 8'h71, 8'h0f, 8'h1a, 8'hc0, 8'h00, 8'h00, 8'h00};
  logic [7:0] mask_t [4] = '{8'hff, 8'hff, 8'h0f, 8'h0f}; // fixed upper bits kept
  logic [3:0] codes [4]  = '{4'ha, 4'h9, 4'h8, 4'h3};    // scaling codes, 3 unlisted

  always #5 clock_i = ~clock_i;

  setr_regs #(.MS_CYCLES(MSC)) dut (.clock_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .touch_pin_i, .touch_level_i,
    .frame_done_i, .bright_i, .sleep_state_o, .poll_o, .exposure_o, .auto_exposure_on_o,
    .touch_info_o, .touch_flag_o);
  setr_host host (.clock_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected scaled touch value; unknown codes pass through
  function automatic logic [7:0] exp_scale(input logic [3:0] c, input logic [7:0] v);
    return (c == 4'h9) ? v >> 1 : (c == 4'h8) ? v >> 2 : v;
  endfunction : exp_scale

  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_cnt(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_cnt
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.read(a, d, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      print_verdict();
    end else chk_byte(d, exp);
  endtask : rd_chk
  // count edges until the wanted event; a used-up bound ends the run
  task automatic wait_for(input int kind, input int lim);
    bit hit;
    hit = 1'b0;
    while (!hit) begin
      @(posedge clock_i);
      #1;
      n++;
      case (kind)
        0: hit = (sleep_state_o === SETR_LIGHT);
        1: hit = (sleep_state_o === SETR_DEEP);
        2: hit = (poll_o === 1'b1);
        default: hit = (sleep_state_o === SETR_NORMAL);
      endcase
      if (n > lim) begin
        mismatches++;
        print_verdict();
      end
    end
  endtask : wait_for
  task automatic frame(input logic [7:0] b);
    @(posedge clock_i);
    frame_done_i <= 1'b1;
    bright_i     <= b;
    @(posedge clock_i);
    frame_done_i <= 1'b0;
  endtask : frame

  // main sequence: reset values, access kinds, scaling, exposure, sleep
  initial begin
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    for (int i = 4; i < 8; i++) host.write(addr_t[i], 8'hff); // read-only and unmapped
    foreach (addr_t[i]) rd_chk(addr_t[i], rst_t[i]);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(lfsr(seed));
      host.write(addr_t[i], (seed[7:0] & mask_t[i]) | (rst_t[i] & ~mask_t[i]));
      rd_chk(addr_t[i], (seed[7:0] & mask_t[i]) | (rst_t[i] & ~mask_t[i]));
    end
    foreach (codes[i]) begin
      host.write(8'h4d, {4'h1, codes[i]});
      seed = lfsr(lfsr(seed));
      @(posedge clock_i) touch_level_i <= seed[7:0];
      repeat (3) @(posedge clock_i);
      #1 chk_byte(touch_info_o, exp_scale(codes[i], seed[7:0]));
    end
    // drive exposure into the upper clamp, then one step back down
    host.write(8'h20, 8'h0f);
    repeat (400) frame(8'h00);
    rd_chk(8'h33, 8'h02);
    rd_chk(8'h32, 8'h00);
    frame(8'hff);
    rd_chk(8'h33, 8'h01);
    rd_chk(8'h32, 8'hff);
    host.write(8'h20, 8'h0e);
    frame(8'h00);
    rd_chk(8'h32, 8'hc0);
    @(posedge clock_i) touch_pin_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    rd_chk(8'h59, 8'h80);
    host.write(8'h0b, 8'h01);
    host.write(8'h0c, 8'h01);
    // release touch: light at 250 ms, deep at 1500 ms, poll every 12 ms
    @(posedge clock_i) touch_pin_i <= 1'b0;
    n = 0;
    wait_for(0, 2000);
    chk_cnt(n, 250 * MSC, 250 * MSC + 12);
    wait_for(1, 8000);
    chk_cnt(n, 1500 * MSC, 1500 * MSC + 12);
    wait_for(2, 9000);
    n = 0;
    wait_for(2, 200);
    chk_cnt(n, 12 * MSC, 12 * MSC);
    @(posedge clock_i) touch_pin_i <= 1'b1;
    n = 0;
    wait_for(3, 20);
    chk_cnt(n, 3, 5);
    print_verdict();
  end
endmodule : sleep_exposure_touch_regs_bench
